/* isd_decoder.sv */
`timescale 1ns/1ps
`include "isd_defs.svh"
module isd_decoder
(
	// Clock and reset
	input logic i_clk,
	input logic i_rst,
	// Window base jumpers (address bits 15..10)
	input logic [5:0] i_base_sel,
	// Bus master side
	input isd_pkg::isd_bus_s i_bus,
	output logic o_dtack,
	output logic [15:0] o_rdata,
	// Module slot side
	output isd_pkg::isd_mod_s o_mod,
	output logic o_mod_clk_en,
	output logic o_mod_reset,
	input logic [3:0] i_mod_ack,
	input logic [15:0] i_mod_rdata,
	input logic [3:0] i_mod_irq,
	input logic [3:0] i_mod_err,
	// Carrier controls
	output logic o_irq,
	output logic [7:0] o_irq_level,
	output logic [7:0] o_mem_enable
);
	import isd_pkg::*;

	localparam int SWRST_CYC_I = `ISD_SWRST_CYC;

	function automatic isd_region_e region_of(input logic [15:1] a,
		input logic [5:0] base);
		if (a[15:10] != base)
			return RG_NONE;
		if (!a[7])
			return RG_IO;
		if (!a[6])
			return RG_ID;
		if (a[9:8] == 2'h0)
			return RG_CAR;
		return RG_VOID;
	endfunction

	isd_bus_s bus_meta_ff, bus_ff;
	logic [5:0] base_meta_ff, base_ff;
	isd_modin_s modin_meta_ff, modin_ff;
	isd_state_e state_ff;
	isd_mod_s mod_ff, nxt_mod;
	logic dtack_ff;
	logic [15:0] rdata_ff;
	logic [4:0] mclk_cnt_ff;
	logic mclk_en_ff;
	logic [5:0] tmo_ff;
	logic ace_ff, aad_ff, toa_ff, gie_ff;
	logic [7:0] lvl_ff, memen_ff;
	logic [7:0] mbase_ff [4];
	logic [3:0] ien_ff, pend_ff;
	logic [7:0] swrst_cnt_ff;
	logic mod_rst_ff, irq_ff;
	logic [7:0] car_rd;
	isd_region_e region;
	logic take, fwd, car_hit, car_wr, car_rd_hit, ack_hit, tmo_hit;
	logic wr_status, rd_status, set_toa, swrst_start, swrst_act;
	logic [7:0] off;

	// Everything from the bus and the slots is asynchronous to i_clk
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			bus_meta_ff <= '0;
			bus_ff <= '0;
			base_meta_ff <= '0;
			base_ff <= '0;
			modin_meta_ff <= '0;
			modin_ff <= '0;
		end
		else
		begin
			bus_meta_ff <= i_bus;
			bus_ff <= bus_meta_ff;
			base_meta_ff <= i_base_sel;
			base_ff <= base_meta_ff;
			modin_meta_ff <= {i_mod_ack, i_mod_rdata, i_mod_irq, i_mod_err};
			modin_ff <= modin_meta_ff;
		end
	end

	assign region = region_of(bus_ff.addr, base_ff);
	assign take = (state_ff == ST_IDLE) && bus_ff.req && (region != RG_NONE);
	assign off = {bus_ff.addr[7:1], 1'b1};
	// ID writes and off-lane ID cycles end locally; data reads as zero
	assign fwd = (region == RG_IO) || ((region == RG_ID)
		&& !bus_ff.wr && bus_ff.lane_lo);
	assign car_hit = take && (region == RG_CAR) && bus_ff.lane_lo;
	assign car_wr = car_hit && bus_ff.wr;
	assign car_rd_hit = car_hit && !bus_ff.wr;
	assign wr_status = car_wr && (off == `ISD_OFF_STATUS);
	assign rd_status = car_rd_hit && (off == `ISD_OFF_STATUS);
	assign ack_hit = |(modin_ff.ack & (mod_ff.io_sel | mod_ff.id_sel));
	assign tmo_hit = tmo_ff == 6'(`ISD_ACK_TMO_MCLK);
	assign set_toa = (state_ff == ST_MOD) && bus_ff.req && !ack_hit
		&& tmo_hit && !aad_ff;
	assign swrst_start = wr_status && bus_ff.wdata[`ISD_ST_SWRST];
	assign swrst_act = swrst_cnt_ff != 8'h00;

	always_comb
	begin
		nxt_mod = '0;
		nxt_mod.offset = bus_ff.addr[6:1];
		nxt_mod.wr = bus_ff.wr;
		nxt_mod.wdata = bus_ff.wdata;
		nxt_mod.lane_lo = bus_ff.lane_lo;
		if (region == RG_IO)
		begin
			nxt_mod.io_sel = 4'h1 << bus_ff.addr[9:8];
			nxt_mod.lane_hi = bus_ff.lane_hi;
		end
		else
			nxt_mod.id_sel = 4'h1 << bus_ff.addr[9:8];
	end

	// Unlisted offsets fall through to zero
	always_comb
	begin
		car_rd = `ISD_RST_BYTE;
		case (off)
			`ISD_OFF_STATUS: car_rd = {ace_ff, aad_ff, toa_ff, 1'b0, gie_ff,
				|pend_ff, 2'b00};
			`ISD_OFF_IRQ_LEVEL: car_rd = lvl_ff;
			`ISD_OFF_ERR: car_rd = {4'h0, modin_ff.err};
			`ISD_OFF_MEM_EN: car_rd = memen_ff;
			`ISD_OFF_MBASE_A: car_rd = mbase_ff[0];
			`ISD_OFF_MBASE_B: car_rd = mbase_ff[1];
			`ISD_OFF_MBASE_C: car_rd = mbase_ff[2];
			`ISD_OFF_MBASE_D: car_rd = mbase_ff[3];
			`ISD_OFF_IRQ_EN: car_rd = {4'h0, ien_ff};
			`ISD_OFF_IRQ_PEND: car_rd = {4'h0, pend_ff};
			default: car_rd = `ISD_RST_BYTE;
		endcase
		if (!car_rd_hit)
			car_rd = `ISD_RST_BYTE;
	end

	// Module clock enable, also paces the acknowledge timeout
	always_ff @(posedge i_clk)
	begin
		if (i_rst || mclk_cnt_ff == 5'(`ISD_MCLK_CYC - 1))
			mclk_cnt_ff <= 5'h00;
		else
			mclk_cnt_ff <= mclk_cnt_ff + 5'h01;
		mclk_en_ff <= !i_rst && (mclk_cnt_ff == 5'(`ISD_MCLK_CYC - 1));
	end

	// Cycle sequencer; dtack holds until the master drops its request
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_ff <= ST_IDLE;
			mod_ff <= '0;
			dtack_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			tmo_ff <= 6'h00;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
					if (take && fwd)
					begin
						mod_ff <= nxt_mod;
						tmo_ff <= 6'h00;
						state_ff <= ST_MOD;
					end
					else if (take)
					begin
						rdata_ff <= {8'h00, car_rd};
						dtack_ff <= 1'b1;
						state_ff <= ST_DONE;
					end
				ST_MOD:
					if (!bus_ff.req)
					begin
						mod_ff <= '0;
						state_ff <= ST_IDLE;
					end
					else if (ack_hit)
					begin
						// Identification_region is odd-lane only, so the high byte is dropped
						rdata_ff <= (mod_ff.id_sel != 4'h0) ?
							{8'h00, modin_ff.rdata[7:0]} :
							modin_ff.rdata;
						dtack_ff <= 1'b1;
						mod_ff <= '0;
						state_ff <= ST_DONE;
					end
					else if (tmo_hit && !aad_ff)
					begin
						rdata_ff <= 16'h0000;
						dtack_ff <= 1'b1;
						mod_ff <= '0;
						state_ff <= ST_DONE;
					end
					else if (mclk_en_ff && !tmo_hit)
						tmo_ff <= tmo_ff + 6'h01;
				ST_DONE:
					if (!bus_ff.req)
					begin
						dtack_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end
			endcase
		end
	end

	// Global status and control
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ace_ff <= 1'b0;
			aad_ff <= 1'b0;
			gie_ff <= 1'b0;
			toa_ff <= 1'b0;
		end
		else
		begin
			if (wr_status)
			begin
				ace_ff <= bus_ff.wdata[`ISD_ST_ACE];
				aad_ff <= bus_ff.wdata[`ISD_ST_AAD];
				gie_ff <= bus_ff.wdata[`ISD_ST_GIE];
			end
			else if (swrst_act)
				gie_ff <= 1'b0;
			if (set_toa)
				toa_ff <= 1'b1;
			else if (rd_status)
				toa_ff <= 1'b0;
		end
	end

	// Remaining carrier registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			lvl_ff <= `ISD_RST_BYTE;
			memen_ff <= `ISD_RST_BYTE;
			mbase_ff <= '{default: `ISD_RST_BYTE};
		end
		else if (car_wr)
		begin
			if (off == `ISD_OFF_IRQ_LEVEL)
				lvl_ff <= bus_ff.wdata[7:0];
			if (off == `ISD_OFF_MEM_EN)
				memen_ff <= bus_ff.wdata[7:0];
			for (int i = 0; i < 4; i++)
				if (off == `ISD_OFF_MBASE_A + 8'(2 * i))
					mbase_ff[i] <= bus_ff.wdata[7:0];
		end
	end

	// Interrupt enable and pending; a new request beats a clear
	always_ff @(posedge i_clk)
	begin
		if (i_rst || swrst_act)
		begin
			ien_ff <= 4'h0;
			pend_ff <= 4'h0;
		end
		else
		begin
			if (car_wr && off == `ISD_OFF_IRQ_EN)
				ien_ff <= bus_ff.wdata[3:0];
			if (ace_ff)
				pend_ff <= modin_ff.irq;
			else if (car_wr && off == `ISD_OFF_IRQ_CLR)
				pend_ff <= (pend_ff & ~bus_ff.wdata[3:0]) | modin_ff.irq;
			else
				pend_ff <= pend_ff | modin_ff.irq;
		end
	end

	// Soft reset: a repeat write while active does not stretch it
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			swrst_cnt_ff <= 8'h00;
		else if (swrst_start && !swrst_act)
			swrst_cnt_ff <= 8'(`ISD_SWRST_CYC);
		else if (swrst_act)
			swrst_cnt_ff <= swrst_cnt_ff - 8'h01;
	end

	always_ff @(posedge i_clk)
	begin
		mod_rst_ff <= i_rst || (swrst_start && !swrst_act)
			|| (swrst_cnt_ff > 8'h01);
		irq_ff <= !i_rst && gie_ff && |(pend_ff & ien_ff);
	end

	assign o_dtack = dtack_ff;
	assign o_rdata = rdata_ff;
	assign o_mod = mod_ff;
	assign o_mod_clk_en = mclk_en_ff;
	assign o_mod_reset = mod_rst_ff;
	assign o_irq = irq_ff;
	assign o_irq_level = lvl_ff;
	assign o_mem_enable = memen_ff;

	// Helper: length of a software reset pulse
	logic [8:0] rst_len_ff;
	logic sw_seen_ff;
	always_ff @(posedge i_clk)
	begin
		rst_len_ff <= (i_rst || !o_mod_reset) ? 9'h000 : rst_len_ff + 9'h001;
		sw_seen_ff <= !i_rst && ((swrst_start && !swrst_act)
			|| (sw_seen_ff && o_mod_reset));
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_window_hit: assert property ($rose(state_ff == ST_MOD) |->
		$past(bus_ff.addr[15:10]) == $past(base_ff))
		else $error("module access outside window");
	a_id_odd_lane: assert property (mod_ff.id_sel != 4'h0 |->
		!mod_ff.lane_hi && mod_ff.lane_lo)
		else $error("ID access on even lane");
	a_id_read_only: assert property (mod_ff.id_sel != 4'h0 |->
		!mod_ff.wr)
		else $error("write forwarded to ID region");
	a_noack_disabled: assert property (state_ff == ST_MOD && tmo_hit
		&& aad_ff && !ack_hit |=> !dtack_ff)
		else $error("carrier acked with auto-ack disabled");
	a_tmo_sets_flag: assert property (set_toa |=>
		toa_ff && dtack_ff && rdata_ff == 16'h0000)
		else $error("timeout did not end cycle and flag it");
	a_read_clears: assert property (rd_status && !set_toa |=>
		!toa_ff ##1 rdata_ff[`ISD_ST_TOA] == $past(toa_ff, 2))
		else $error("status read did not clear timeout flag");
	a_irq_gated: assert property (!gie_ff |=> !o_irq)
		else $error("interrupt while globally disabled");
	a_swrst_width: assert property ($fell(o_mod_reset) && sw_seen_ff
		|-> rst_len_ff == 9'(SWRST_CYC_I))
		else $error("soft reset pulse has wrong length");

	c_mod_read: cover property (state_ff == ST_MOD ##1 ack_hit ##1 dtack_ff);
	c_timeout: cover property (set_toa ##1 toa_ff);
	c_soft_reset: cover property ($fell(o_mod_reset) && sw_seen_ff);
	c_status_read: cover property (rd_status);

endmodule

/* isd_defs.svh */
`ifndef ISD_DEFS_SVH
`define ISD_DEFS_SVH

// System clock
`define ISD_CLK_NS 4

// Module clock: 8 MHz period, longest whole count of system cycles
`define ISD_MCLK_NS 125
`define ISD_MCLK_CYC (`ISD_MCLK_NS / `ISD_CLK_NS)

// Software reset pulse: least time, rounded up
`define ISD_SWRST_NS 1000
`define ISD_SWRST_CYC ((`ISD_SWRST_NS + `ISD_CLK_NS - 1) / `ISD_CLK_NS)

// Module acknowledge timeout, in module clock periods
`define ISD_ACK_TMO_MCLK 32

// Carrier register byte offsets (odd lane)
`define ISD_OFF_STATUS 8'hc1
`define ISD_OFF_IRQ_LEVEL 8'hc3
`define ISD_OFF_ERR 8'hc5
`define ISD_OFF_MEM_EN 8'hc7
`define ISD_OFF_MBASE_A 8'hd1
`define ISD_OFF_MBASE_B 8'hd3
`define ISD_OFF_MBASE_C 8'hd5
`define ISD_OFF_MBASE_D 8'hd7
`define ISD_OFF_IRQ_EN 8'he1
`define ISD_OFF_IRQ_PEND 8'he3
`define ISD_OFF_IRQ_CLR 8'he5

// Status register bit positions
`define ISD_ST_ACE 7
`define ISD_ST_AAD 6
`define ISD_ST_TOA 5
`define ISD_ST_SWRST 4
`define ISD_ST_GIE 3
`define ISD_ST_GIP 2

// Reset values
`define ISD_RST_BYTE 8'h00

`endif

/* isd_pkg.sv */
package isd_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_MOD,
		ST_DONE
	} isd_state_e;

	typedef enum logic [2:0]
	{
		RG_NONE,
		RG_IO,
		RG_ID,
		RG_CAR,
		RG_VOID
	} isd_region_e;

	// Short I/O cycle as presented by the bus master
	typedef struct packed
	{
		logic req;
		logic wr;
		logic lane_hi;
		logic lane_lo;
		logic [15:1] addr;
		logic [15:0] wdata;
	} isd_bus_s;

	// Access forwarded to the module slots
	typedef struct packed
	{
		logic [3:0] io_sel;
		logic [3:0] id_sel;
		logic [5:0] offset;
		logic wr;
		logic lane_hi;
		logic lane_lo;
		logic [15:0] wdata;
	} isd_mod_s;

	// Module-side inputs, gathered for synchronising
	typedef struct packed
	{
		logic [3:0] ack;
		logic [15:0] rdata;
		logic [3:0] irq;
		logic [3:0] err;
	} isd_modin_s;

endpackage

/* isd_slot_model.sv */
`timescale 1ns/1ps
module isd_slot_model
(
	// Forwarded access
	input logic i_clk,
	input isd_pkg::isd_mod_s i_mod,
	// Slot behaviour: absent mask per slot, one wait count for all slots
	input logic [3:0] i_absent,
	input logic [7:0] i_wait,
	// Answer
	output logic [3:0] o_ack,
	output logic [15:0] o_rdata
);
	import isd_pkg::*;
	logic [15:0] mem [0:1023];
	logic [7:0] rom [0:31];
	logic [3:0] sel;
	logic [9:0] idx;
	int cnt;

	assign sel = i_mod.io_sel | i_mod.id_sel;
	assign idx = {sel, i_mod.offset};

	initial
	begin
		for (int i = 0; i < 32; i++)
			rom[i] = 8'h00;
		// Arbitrary signature and maker values
		rom[0] = 8'h5a;
		rom[1] = 8'h3c;
		rom[2] = 8'h96;
		rom[3] = 8'h69;
		rom[4] = 8'h7e;
		rom[5] = 8'h12;
		rom[10] = 8'h10;
		rom[11] = 8'hc5;
		for (int i = 12; i < 16; i++)
			rom[i] = 8'h80 + 8'(i);
		o_ack = 4'h0;
		o_rdata = 16'h0000;
		cnt = 0;
	end

	// Released data bus never shows its last value
	always @(posedge i_clk)
	begin
		if (sel == 4'h0 || (sel & i_absent) != 4'h0)
		begin
			o_ack <= 4'h0;
			o_rdata <= ~o_rdata;
			cnt <= 0;
		end
		else if (cnt < int'(i_wait))
			cnt <= cnt + 1;
		else if (o_ack == 4'h0)
		begin
			o_ack <= sel;
			if (i_mod.wr && i_mod.lane_hi)
				mem[idx][15:8] <= i_mod.wdata[15:8];
			if (i_mod.wr && i_mod.lane_lo)
				mem[idx][7:0] <= i_mod.wdata[7:0];
			// Junk on the unused ID even lane
			if (i_mod.id_sel != 4'h0)
				o_rdata <= {8'hee, rom[i_mod.offset[4:0]]};
			else
				o_rdata <= mem[idx];
		end
	end
endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "isd_defs.svh"
module tb;
	import isd_pkg::*;
	localparam logic [15:0] BA = 16'hb400;
	localparam logic [7:0] IDV [6] = '{8'h5a, 8'h3c, 8'h96, 8'h69,
		8'h7e, 8'h12};
	logic clk, rst, dtack, irq, mrst;
	logic [15:0] rdata, mrd;
	logic [3:0] ack, mirq, merr, absent;
	logic [7:0] lvl, wt;
	isd_bus_s bus;
	isd_mod_s mo;
	int error_cnt, n_checks, hi_n;
	bit idwr;

	isd_decoder dut
	(
		.i_clk(clk), .i_rst(rst), .i_base_sel(BA[15:10]), .i_bus(bus),
		.o_dtack(dtack), .o_rdata(rdata), .o_mod(mo), .o_mod_clk_en(),
		.o_mod_reset(mrst), .i_mod_ack(ack), .i_mod_rdata(mrd),
		.i_mod_irq(mirq), .i_mod_err(merr), .o_irq(irq),
		.o_irq_level(lvl), .o_mem_enable()
	);
	isd_slot_model slots
	(
		.i_clk(clk), .i_mod(mo), .i_absent(absent), .i_wait(wt),
		.o_ack(ack), .o_rdata(mrd)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(negedge clk)
	begin
		if (mrst === 1'b1)
			hi_n++;
		if (mo.id_sel != 4'h0 && mo.wr === 1'b1)
			idwr = 1;
	end

	task tally_and_finish;
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s exp %h got %h", s, e, g);
			error_cnt++;
		end
	endtask

	// One short I/O cycle; req held until dtack or 1200 cycles, then dropped
	task automatic cyc(input logic w, input logic [1:0] ln,
		input logic [15:0] a, input logic [15:0] d, input bit need,
		output logic [15:0] q, output bit got);
		got = 0;
		q = 16'hxxxx;
		@(negedge clk);
		bus.wr = w;
		{bus.lane_hi, bus.lane_lo} = ln;
		bus.addr = a[15:1];
		bus.wdata = d;
		bus.req = 1'b1;
		for (int i = 0; i < 1200 && !got; i++)
		begin
			@(negedge clk);
			if (dtack === 1'b1)
			begin
				got = 1;
				q = rdata;
			end
		end
		bus.req = 1'b0;
		for (int i = 0; i < 8 && dtack !== 1'b0; i++)
			@(negedge clk);
		if (need && !got)
		begin
			$display("[FAIL] dtack exp 1 got 0");
			error_cnt++;
			tally_and_finish;
		end
	endtask

	task automatic rd(input logic [1:0] ln, input logic [15:0] a,
		input logic [15:0] e, input string s);
		logic [15:0] q;
		bit g;
		cyc(1'b0, ln, a, 16'h0000, 1, q, g);
		chk(s, e, q);
	endtask

	task automatic wr(input logic [1:0] ln, input logic [15:0] a,
		input logic [15:0] d);
		logic [15:0] q;
		bit g;
		cyc(1'b1, ln, a, d, 1, q, g);
	endtask

	initial
	begin
		logic [15:0] q, sb, dv;
		bit g;
		bus = '0;
		rst = 1'b1;
		{mirq, merr, absent} = '0;
		wt = 8'd2;
		{error_cnt, n_checks, hi_n} = '0;
		idwr = 0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk("mod_reset", 16'h0000, {15'h0, mrst});
		rd(2'b01, BA + 16'hc1, 16'h0000, "status_rst");
		wr(2'b01, BA + 16'hc1, 16'h00cb);
		wr(2'b10, BA + 16'hc0, 16'hff00);
		rd(2'b01, BA + 16'hc1, 16'h00c8, "status_rw");
		rd(2'b10, BA + 16'hc0, 16'h0000, "even_lane");
		wr(2'b01, BA + 16'hc9, 16'h00ff);
		rd(2'b01, BA + 16'hc9, 16'h0000, "gap");
		wr(2'b01, BA + 16'hc3, 16'h005a);
		chk("irq_level", 16'h005a, {8'h00, lvl});
		merr = 4'h5;
		rd(2'b01, BA + 16'hc5, 16'h0005, "err");
		wr(2'b01, BA + 16'hc1, 16'h0008);
		wr(2'b01, BA + 16'he1, 16'h0001);
		mirq = 4'h1;
		rd(2'b01, BA + 16'hc1, 16'h000c, "gip");
		chk("irq_on", 16'h0001, {15'h0, irq});
		mirq = 4'h0;
		rd(2'b01, BA + 16'he3, 16'h0001, "pend_hold");
		wr(2'b01, BA + 16'he5, 16'h0001);
		rd(2'b01, BA + 16'he3, 16'h0000, "pend_clr");
		wr(2'b01, BA + 16'hc1, 16'h0000);
		mirq = 4'h1;
		rd(2'b01, BA + 16'hc1, 16'h0004, "gip_raw");
		chk("irq_gated", 16'h0000, {15'h0, irq});
		mirq = 4'h0;
		wr(2'b01, BA + 16'hc1, 16'h0080);
		rd(2'b01, BA + 16'he3, 16'h0000, "auto_clr");
		for (int s = 0; s < 4; s++)
		begin
			// Last slot answers slowly
			wt = (s == 3) ? 8'd30 : 8'd2;
			sb = BA + 16'(s * 256);
			dv = {8'h12, 4'h3, 4'(s)};
			wr(2'b11, sb + 16'h10, dv);
			wr(2'b10, sb + 16'h10, 16'hab00);
			rd(2'b11, sb + 16'h10, {8'hab, dv[7:0]}, "io");
			for (int k = 0; k < 6; k++)
				rd(2'b01, sb + 16'h81 + 16'(2 * k), {8'h00, IDV[k]}, "id");
			rd(2'b10, sb + 16'h80, 16'h0000, "id_even");
			wr(2'b01, sb + 16'h81, 16'h00ff);
		end
		chk("id_write", 16'h0000, {15'h0, idwr});
		rd(2'b01, BA + 16'h1c1, 16'h0000, "spare_b");
		cyc(1'b0, 2'b01, BA ^ 16'h0400, 16'h0000, 0, q, g);
		chk("out_of_window", 16'h0000, {15'h0, g});
		wt = 8'd2;
		absent = 4'h4;
		cyc(1'b0, 2'b11, BA + 16'h210, 16'h0000, 0, q, g);
		chk("tmo_ack", 16'h0001, {15'h0, g});
		rd(2'b01, BA + 16'hc1, 16'h00a0, "toa_set");
		rd(2'b01, BA + 16'hc1, 16'h0080, "toa_clr");
		wr(2'b01, BA + 16'hc1, 16'h00c0);
		cyc(1'b0, 2'b11, BA + 16'h210, 16'h0000, 0, q, g);
		chk("aad_none", 16'h0000, {15'h0, g});
		absent = 4'h0;
		wr(2'b01, BA + 16'he1, 16'h0001);
		hi_n = 0;
		wr(2'b01, BA + 16'hc1, 16'h0018);
		for (int i = 0; i < 400 && mrst !== 1'b0; i++)
			@(negedge clk);
		chk("swrst_len", 16'(`ISD_SWRST_CYC), 16'(hi_n));
		rd(2'b01, BA + 16'hc1, 16'h0000, "swrst_gie");
		rd(2'b01, BA + 16'he1, 16'h0000, "swrst_en");
		hi_n = 0;
		wr(2'b01, BA + 16'hc1, 16'h0008);
		rd(2'b01, BA + 16'hc1, 16'h0008, "zero_wr");
		chk("no_swrst", 16'h0000, 16'(hi_n));
		tally_and_finish;
	end
endmodule
